// ==== design/sspc_regs.v ====
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sspc_consts.vh"

// Behaviour
// - SPI master samples at end when phase set
// - Shift edge from clock edge and polarity
// - Start/stop seen flags, cleared when disabled
// - I2C master buffer write when blocked collides
// - SPI slave overflow discards new byte
// - SPI master never sets overflow
// - I2C receive overflow, ignored when transmitting
// - Enable routes SPI pins to port
// - SPI idle clock level follows polarity
// - I2C slave polarity bit releases clock
// - Mode codes select SPI master/slave variants
// - Acknowledge request sends ack value, self-clears
// - Stop request self-clears when done
// - Restart request self-clears when done
// - Start request self-clears when done
// - Buffer read clears buffer full
module sspc_regs (
   // Clock and reset
   input  wire       i_clock,
   input  wire       i_rst_n,
   // Register port
   input  wire [1:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_wr,
   input  wire       i_rd,
   output reg  [7:0] o_rdata,
   // Shift engine events and state
   input  wire       i_byte_done,
   input  wire [7:0] i_rx_byte,
   input  wire       i_shift_busy,
   input  wire       i_tx_busy,
   input  wire       i_bus_blocked,
   input  wire       i_start_seen,
   input  wire       i_stop_seen,
   input  wire       i_addr_match,
   input  wire       i_rw_bit,
   input  wire       i_last_was_data,
   input  wire       i_addr_update,
   input  wire       i_ack_rx_status,
   input  wire [4:0] i_seq_done,
   input  wire       i_timer_tick,
   // Shift engine control
   output reg  [7:0] o_tx_byte,
   output reg        o_tx_load,
   output reg  [4:0] o_seq_request,
   output wire       o_ack_value,
   output wire       o_bit_tick,
   output wire       o_sample_at_end,
   output wire       o_shift_on_rise,
   // Mode decode
   output wire       o_spi_master,
   output wire       o_spi_slave,
   output wire       o_ss_control,
   output wire       o_i2c_master,
   output wire       o_i2c_slave,
   output wire       o_addr_10bit,
   output wire       o_start_stop_irq,
   output wire       o_general_call,
   output wire       o_mode_reserved,
   // Pin routing
   output wire       o_spi_pins_on,
   output wire       o_i2c_pins_on,
   output wire       o_sck_idle_level,
   output wire       o_scl_hold_low
);

   reg  [7:0] status_reg;
   reg  [7:0] status_next;
   reg  [7:0] ctrl_one_reg;
   reg  [7:0] ctrl_one_next;
   reg  [7:0] ctrl_two_reg;
   reg  [7:0] ctrl_two_next;
   reg  [7:0] buffer_reg;
   reg  [7:0] buffer_next;
   reg  [7:0] tx_next;
   reg        load_next;
   reg  [7:0] rdata_next;

   wire [3:0] mode;
   wire       enable;
   wire       spi_mode;
   wire       i2c_mode;
   wire       idle;
   wire       wr_status;
   wire       wr_one;
   wire       wr_two;
   wire       wr_buf;
   wire       rd_buf;
   wire       collide;
   wire       overflow;
   wire       buf_full;

   // Mode class decoding, shared by routing and flag logic
   function is_spi_master;
      input [3:0] m;
      begin
         is_spi_master = (m <= `SSPC_M_SPI_TMR);
      end
   endfunction

   function is_spi_slave;
      input [3:0] m;
      begin
         is_spi_slave = (m == `SSPC_M_SPI_SLV_SS) || (m == `SSPC_M_SPI_SLV);
      end
   endfunction

   function is_i2c_master;
      input [3:0] m;
      begin
         is_i2c_master = (m == `SSPC_M_I2C_MST) || (m == `SSPC_M_I2C_FWMST);
      end
   endfunction

   function is_i2c_slave;
      input [3:0] m;
      begin
         is_i2c_slave = (m == `SSPC_M_I2C_SLV7) || (m == `SSPC_M_I2C_SLV10) ||
                        (m == `SSPC_M_I2C_SLV7_IRQ) || (m == `SSPC_M_I2C_SLV10_IRQ);
      end
   endfunction

   assign mode     = ctrl_one_reg[`SSPC_C1_MODE_HI:`SSPC_C1_MODE_LO];
   assign enable   = ctrl_one_reg[`SSPC_C1_EN];
   assign spi_mode = is_spi_master(mode) | is_spi_slave(mode);
   assign i2c_mode = is_i2c_master(mode) | is_i2c_slave(mode);
   assign buf_full = status_reg[`SSPC_ST_FULL];

   // Mode outputs, only live while the port is enabled, except o_mode_reserved and o_ack_value
   assign o_spi_master     = enable & is_spi_master(mode);
   assign o_spi_slave      = enable & is_spi_slave(mode);
   assign o_ss_control     = enable & (mode == `SSPC_M_SPI_SLV_SS);
   assign o_i2c_master     = enable & is_i2c_master(mode);
   assign o_i2c_slave      = enable & is_i2c_slave(mode);
   assign o_addr_10bit     = o_i2c_slave & mode[0];
   assign o_start_stop_irq = o_i2c_slave & mode[3];
   assign o_mode_reserved  = ~spi_mode & ~i2c_mode;
   assign o_general_call   = o_i2c_slave & ctrl_two_reg[`SSPC_C2_GCALL];
   assign o_ack_value      = ctrl_two_reg[`SSPC_C2_ACKV];

   // Pin routing and clock levels
   assign o_spi_pins_on    = enable & spi_mode;
   assign o_i2c_pins_on    = enable & i2c_mode;
   assign o_sck_idle_level = ctrl_one_reg[`SSPC_C1_POL];
   assign o_scl_hold_low   = o_i2c_slave & ~ctrl_one_reg[`SSPC_C1_POL];
   // Phase only acts in SPI master mode; sample at end is held low in every other mode
   assign o_sample_at_end  = o_spi_master & status_reg[`SSPC_ST_PHASE];
   assign o_shift_on_rise  = status_reg[`SSPC_ST_CKE] ^ ctrl_one_reg[`SSPC_C1_POL];

   // Idle when no transmit and no pending request
   assign idle = ~(status_reg[`SSPC_ST_RW] | (|ctrl_two_reg[`SSPC_C2_REQ_HI:`SSPC_C2_REQ_LO]));

   // Register port strobes
   assign wr_status = i_wr & (i_addr == `SSPC_OFF_STATUS);
   assign wr_one    = i_wr & (i_addr == `SSPC_OFF_CTRL_ONE);
   assign wr_two    = i_wr & (i_addr == `SSPC_OFF_CTRL_TWO);
   assign wr_buf    = i_wr & (i_addr == `SSPC_OFF_BUFFER);
   assign rd_buf    = i_rd & (i_addr == `SSPC_OFF_BUFFER);

   // Buffer writes that cannot be taken; the word is dropped
   assign collide = wr_buf & enable &
                    ((is_i2c_master(mode) & (~idle | i_bus_blocked)) |
                     (~is_i2c_master(mode) & i_shift_busy));

   // Overflow only in SPI slave and I2C modes; in I2C modes only on a byte received while not transmitting
   assign overflow = enable & i_byte_done & buf_full & ~rd_buf &
                     (is_spi_slave(mode) |
                      (i2c_mode & ~i_tx_busy));

   // Master bit rate enable; the low mode bits pick the rate
   sspc_rate_div u_rate_div (
      .i_clock      (i_clock),
      .i_rst_n      (i_rst_n),
      .i_run        (o_spi_master),
      .i_rate_sel   (mode[1:0]),
      .i_timer_tick (i_timer_tick),
      .o_bit_tick   (o_bit_tick)
   );

   // Status register: two config bits, the rest follow the engine
   always @* begin
      status_next = status_reg;
      if (wr_status) begin
         status_next[`SSPC_ST_PHASE] = i_wdata[`SSPC_ST_PHASE];
         status_next[`SSPC_ST_CKE] = i_wdata[`SSPC_ST_CKE];
      end
      if (!enable || !i2c_mode) begin
         status_next[`SSPC_ST_STOP]      = 1'b0;
         status_next[`SSPC_ST_START]     = 1'b0;
         status_next[`SSPC_ST_RW]        = 1'b0;
         status_next[`SSPC_ST_UPD]       = 1'b0;
         status_next[`SSPC_ST_DATA_ADDR] = 1'b0;
      end else begin
         // Whichever condition came last wins
         if (i_start_seen) begin
            status_next[`SSPC_ST_START] = 1'b1;
            status_next[`SSPC_ST_STOP]  = 1'b0;
         end else if (i_stop_seen) begin
            status_next[`SSPC_ST_STOP]  = 1'b1;
            status_next[`SSPC_ST_START] = 1'b0;
         end
         if (is_i2c_master(mode)) begin
            status_next[`SSPC_ST_RW] = i_tx_busy;
         end else if (i_addr_match) begin
            status_next[`SSPC_ST_RW] = i_rw_bit;
         end
         if (i_byte_done) begin
            status_next[`SSPC_ST_DATA_ADDR] = i_last_was_data;
         end
         status_next[`SSPC_ST_UPD] = is_i2c_slave(mode) & mode[0] & i_addr_update;
      end
      // Buffer full: a new byte beats a same-cycle read
      if (rd_buf) begin
         status_next[`SSPC_ST_FULL] = 1'b0;
      end
      if (enable && i_byte_done && !overflow) begin
         status_next[`SSPC_ST_FULL] = 1'b1;
      end
      if (!enable) begin
         status_next[`SSPC_ST_FULL] = 1'b0;
      end
   end

   // Control one: error flags are cleared by software, set wins
   always @* begin
      ctrl_one_next = ctrl_one_reg;
      if (wr_one) begin
         ctrl_one_next = i_wdata;
      end
      if (collide) begin
         ctrl_one_next[`SSPC_C1_COLL] = 1'b1;
      end
      if (overflow) begin
         ctrl_one_next[`SSPC_C1_OVF] = 1'b1;
      end
   end

   // Control two: requests taken only by an idle, enabled master
   always @* begin
      ctrl_two_next = ctrl_two_reg;
      ctrl_two_next[`SSPC_C2_ACKRX] = i_ack_rx_status;
      if (wr_two) begin
         ctrl_two_next[`SSPC_C2_GCALL] = i_wdata[`SSPC_C2_GCALL];
         ctrl_two_next[`SSPC_C2_ACKV]  = i_wdata[`SSPC_C2_ACKV];
         if (o_i2c_master && idle) begin
            ctrl_two_next[`SSPC_C2_REQ_HI:`SSPC_C2_REQ_LO] =
               i_wdata[`SSPC_C2_REQ_HI:`SSPC_C2_REQ_LO];
         end
      end
      // Engine completion clears each request bit by itself
      ctrl_two_next[`SSPC_C2_REQ_HI:`SSPC_C2_REQ_LO] =
         ctrl_two_next[`SSPC_C2_REQ_HI:`SSPC_C2_REQ_LO] & ~i_seq_done;
      if (!o_i2c_master) begin
         ctrl_two_next[`SSPC_C2_REQ_HI:`SSPC_C2_REQ_LO] = 5'h00;
      end
   end

   // Buffer: receive path, and transmit hand-off when no collision
   always @* begin
      buffer_next = buffer_reg;
      tx_next     = o_tx_byte;
      load_next   = 1'b0;
      if (wr_buf && enable && !collide) begin
         buffer_next = i_wdata;
         tx_next     = i_wdata;
         load_next   = 1'b1;
      end
      // Overflowed byte is discarded, the old one kept
      if (enable && i_byte_done && !overflow) begin
         buffer_next = i_rx_byte;
      end
   end

   // Read data mux, unmapped offsets cannot occur with two bits
   always @* begin
      case (i_addr)
         `SSPC_OFF_STATUS:   rdata_next = status_reg;
         `SSPC_OFF_CTRL_ONE: rdata_next = ctrl_one_reg;
         `SSPC_OFF_CTRL_TWO: rdata_next = ctrl_two_reg;
         `SSPC_OFF_BUFFER:   rdata_next = buffer_reg;
         default:            rdata_next = `SSPC_RST_BYTE;
      endcase
      if (!i_rd) begin
         rdata_next = `SSPC_RST_BYTE;
      end
   end

   // State registers, all zero at reset
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         status_reg    <= `SSPC_RST_BYTE;
         ctrl_one_reg  <= `SSPC_RST_BYTE;
         ctrl_two_reg  <= `SSPC_RST_BYTE;
         buffer_reg    <= `SSPC_RST_BYTE;
         o_tx_byte     <= `SSPC_RST_BYTE;
         o_tx_load     <= 1'b0;
         o_seq_request <= 5'h00;
         o_rdata       <= `SSPC_RST_BYTE;
      end else begin
         status_reg    <= status_next;
         ctrl_one_reg  <= ctrl_one_next;
         ctrl_two_reg  <= ctrl_two_next;
         buffer_reg    <= buffer_next;
         o_tx_byte     <= tx_next;
         o_tx_load     <= load_next;
         o_seq_request <= ctrl_two_next[`SSPC_C2_REQ_HI:`SSPC_C2_REQ_LO];
         o_rdata       <= rdata_next;
      end
   end

endmodule
`default_nettype wire

// ==== design/sspc_consts.vh ====
`ifndef SSPC_CONSTS_VH
`define SSPC_CONSTS_VH

// Register offsets on the plain register port
`define SSPC_ADDR_W          2
`define SSPC_OFF_STATUS      2'h0
`define SSPC_OFF_CTRL_ONE    2'h1
`define SSPC_OFF_CTRL_TWO    2'h2
`define SSPC_OFF_BUFFER      2'h3

// Reset values
`define SSPC_RST_BYTE        8'h00

// serial_status fields
`define SSPC_ST_PHASE        7
`define SSPC_ST_CKE          6
`define SSPC_ST_DATA_ADDR    5
`define SSPC_ST_STOP         4
`define SSPC_ST_START        3
`define SSPC_ST_RW           2
`define SSPC_ST_UPD          1
`define SSPC_ST_FULL         0

// serial_control_one fields
`define SSPC_C1_COLL         7
`define SSPC_C1_OVF          6
`define SSPC_C1_EN           5
`define SSPC_C1_POL          4
`define SSPC_C1_MODE_HI      3
`define SSPC_C1_MODE_LO      0

// serial_control_two fields
`define SSPC_C2_GCALL        7
`define SSPC_C2_ACKRX        6
`define SSPC_C2_ACKV         5
`define SSPC_C2_REQ_HI       4
`define SSPC_C2_REQ_LO       0

// Request vector positions (ack, receive, stop, restart, start)
`define SSPC_REQ_ACK         4
`define SSPC_REQ_RCV         3
`define SSPC_REQ_STOP        2
`define SSPC_REQ_RESTART     1
`define SSPC_REQ_START       0

// Mode select codes
`define SSPC_M_SPI_DIV4      4'h0
`define SSPC_M_SPI_DIV16     4'h1
`define SSPC_M_SPI_DIV64     4'h2
`define SSPC_M_SPI_TMR       4'h3
`define SSPC_M_SPI_SLV_SS    4'h4
`define SSPC_M_SPI_SLV       4'h5
`define SSPC_M_I2C_SLV7      4'h6
`define SSPC_M_I2C_SLV10     4'h7
`define SSPC_M_I2C_MST       4'h8
`define SSPC_M_I2C_FWMST     4'hb
`define SSPC_M_I2C_SLV7_IRQ  4'he
`define SSPC_M_I2C_SLV10_IRQ 4'hf

// Master bit clock terminal counts, one less than the divide in system clock cycles
`define SSPC_DIV4            6'h03
`define SSPC_DIV16           6'h0f
`define SSPC_DIV64           6'h3f

`endif

// ==== design/sspc_rate_div.v ====
`timescale 1ns/10ps
`default_nettype none
`include "sspc_consts.vh"

module sspc_rate_div (
   // Clock and reset
   input  wire       i_clock,
   input  wire       i_rst_n,
   // Control
   input  wire       i_run,
   input  wire [1:0] i_rate_sel,
   input  wire       i_timer_tick,
   // Rate output
   output reg        o_bit_tick
);

   reg  [5:0] count_reg;
   reg  [5:0] count_next;
   reg        tmr_half_reg;
   reg        tmr_half_next;
   reg        tick_next;
   reg  [5:0] limit;

   // Divider terminal count per rate selection
   always @* begin
      case (i_rate_sel)
         2'h0:    limit = `SSPC_DIV4;
         2'h1:    limit = `SSPC_DIV16;
         default: limit = `SSPC_DIV64;
      endcase
   end

   // Timer rate halves the timer ticks; others count system clocks
   always @* begin
      count_next    = count_reg;
      tmr_half_next = tmr_half_reg;
      tick_next     = 1'b0;
      if (!i_run) begin
         count_next    = 6'h00;
         tmr_half_next = 1'b0;
      end else if (i_rate_sel == 2'h3) begin
         if (i_timer_tick) begin
            tmr_half_next = ~tmr_half_reg;
            tick_next     = tmr_half_reg;
         end
      end else if (count_reg >= limit) begin
         count_next = 6'h00;
         tick_next  = 1'b1;
      end else begin
         count_next = count_reg + 6'h01;
      end
   end

   // Restart from zero whenever the port stops, so the first bit is full length
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         count_reg    <= 6'h00;
         tmr_half_reg <= 1'b0;
         o_bit_tick   <= 1'b0;
      end else begin
         count_reg    <= count_next;
         tmr_half_reg <= tmr_half_next;
         o_bit_tick   <= tick_next;
      end
   end

endmodule
`default_nettype wire

// ==== sim/sspc_regs_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module sspc_regs_monitor (
   // Clock and reset
   input wire logic       i_clock,
   input wire logic       i_rst_n,
   // Register port
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   // Engine side
   input wire logic       i_shift_busy,
   input wire logic       i_bus_blocked,
   input wire logic [4:0] i_seq_done,
   input wire logic       o_tx_load,
   input wire logic [4:0] o_seq_request,
   input wire logic       o_sample_at_end,
   input wire logic       o_shift_on_rise,
   // Mode and pins
   input wire logic       o_spi_master,
   input wire logic       o_spi_slave,
   input wire logic       o_i2c_master,
   input wire logic       o_mode_reserved,
   input wire logic       o_spi_pins_on,
   input wire logic       o_sck_idle_level
);
   logic       phs_reg;
   logic       cke_reg;
   logic [5:0] c1_reg;
   // Shadows of fields only software changes; flags left out
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         phs_reg <= 1'b0;
         cke_reg <= 1'b0;
         c1_reg  <= 6'h00;
      end else if (i_wr && i_addr == 2'h0) begin
         phs_reg <= i_wdata[7];
         cke_reg <= i_wdata[6];
      end else if (i_wr && i_addr == 2'h1) begin
         c1_reg <= i_wdata[5:0];
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   sample_phase_a: assert property (o_spi_master |-> o_sample_at_end == phs_reg)
      else $error("sample phase wrong");
   shift_edge_a: assert property (o_shift_on_rise == (cke_reg ^ c1_reg[4]))
      else $error("shift edge wrong");
   idle_level_a: assert property (o_sck_idle_level == c1_reg[4])
      else $error("idle level wrong");
   spi_master_a: assert property (o_spi_master == (c1_reg[5] && c1_reg[3:0] <= 4'h3))
      else $error("master decode wrong");
   reserved_code_a: assert property (o_mode_reserved == (c1_reg[3:0] inside {4'h9, 4'ha, 4'hc, 4'hd}))
      else $error("reserved decode wrong");
   spi_pins_a: assert property (o_spi_pins_on == (o_spi_master || o_spi_slave))
      else $error("pin routing wrong");
   req_clear_a: assert property ((o_seq_request & i_seq_done) != 5'h00
      |=> (o_seq_request & $past(i_seq_done)) == 5'h00) else $error("request not cleared");
   busy_ignore_a: assert property (o_seq_request != 5'h00 && i_wr && i_addr == 2'h2
      |=> o_seq_request == ($past(o_seq_request) & ~$past(i_seq_done))) else $error("request queued");
   slave_collide_a: assert property (i_wr && i_addr == 2'h3 && o_spi_slave && i_shift_busy
      |=> !o_tx_load) else $error("slave write not refused");
   bus_collide_a: assert property (i_wr && i_addr == 2'h3 && o_i2c_master && i_bus_blocked
      |=> !o_tx_load) else $error("blocked write not refused");
endmodule
`default_nettype wire

// ==== sim/sspc_engine_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sspc_engine_model (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   // Bench controls
   input  wire logic       i_kick,
   input  wire logic [7:0] i_kick_byte,
   input  wire logic       i_talk,
   input  wire logic       i_slow,
   // Port side
   input  wire logic       i_tx_load,
   input  wire logic [7:0] i_tx_byte,
   input  wire logic [4:0] i_seq_request,
   output logic            o_byte_done,
   output logic [7:0]      o_rx_byte,
   output logic            o_shift_busy,
   output logic            o_tx_busy,
   output logic [4:0]      o_seq_done
);
   logic [3:0] bit_cnt;
   logic [3:0] seq_cnt;
   logic [7:0] shift_reg;
   // Busy through the hand-over cycle, so a transmit masks overflow
   assign o_shift_busy = (bit_cnt != 4'h0) || o_byte_done;
   assign o_tx_busy    = o_shift_busy & i_talk;
   // Eight bit times a byte; data bus toggles when nothing is valid
   always @(posedge i_clock) begin
      o_byte_done <= 1'b0;
      o_rx_byte   <= ~o_rx_byte;
      if (!i_rst_n) begin
         bit_cnt   <= 4'h0;
         o_rx_byte <= 8'h00;
      end else if (i_kick || i_tx_load) begin
         bit_cnt   <= 4'h8;
         shift_reg <= i_kick ? i_kick_byte : ~i_tx_byte;
      end else if (bit_cnt != 4'h0) begin
         bit_cnt <= bit_cnt - 4'h1;
         if (bit_cnt == 4'h1) begin
            o_byte_done <= 1'b1;
            o_rx_byte   <= shift_reg;
         end
      end
   end
   // Bus conditions finish promptly or slowly, then report done once
   always @(posedge i_clock) begin
      o_seq_done <= 5'h00;
      if (!i_rst_n || i_seq_request == 5'h00 || o_seq_done != 5'h00) begin
         seq_cnt <= 4'h0;
      end else if (seq_cnt == (i_slow ? 4'hc : 4'h5)) begin
         o_seq_done <= i_seq_request;
      end else begin
         seq_cnt <= seq_cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ==== sim/sync_serial_port_control_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_control_tb_top;
   logic       i_clock = 1'b0;
   logic       i_rst_n = 1'b0;
   logic [1:0] i_addr = 2'h0;
   logic [7:0] i_wdata = 8'h00;
   logic       i_wr = 1'b0, i_rd = 1'b0, i_bus_blocked = 1'b0, i_timer_tick = 1'b0;
   logic       i_start_seen = 1'b0, i_stop_seen = 1'b0, i_ack_rx_status = 1'b0;
   logic       kick = 1'b0, talk = 1'b0, slow = 1'b0, rd_seen = 1'b0;
   logic [7:0] kick_byte = 8'h00, o_rdata, o_tx_byte, i_rx_byte;
   logic [4:0] o_seq_request, i_seq_done;
   logic       o_tx_load, o_sample_at_end, o_shift_on_rise, o_spi_master, o_spi_slave, o_i2c_master;
   logic       o_i2c_slave, o_mode_reserved, o_spi_pins_on, o_sck_idle_level, o_scl_hold_low;
   logic       o_ack_value, o_ss_control, o_i2c_pins_on, o_addr_10bit, o_start_stop_irq, o_general_call, o_bit_tick;
   logic       i_byte_done, i_shift_busy, i_tx_busy;
   logic [7:0] expq[$];
   int         n_mismatch = 0, checks_done = 0, cycles = 0, ticks = 0;
   sspc_regs DUT (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_byte_done, .i_rx_byte,
      .i_shift_busy, .i_tx_busy, .i_bus_blocked, .i_start_seen, .i_stop_seen, .i_addr_match(1'b0),
      .i_rw_bit(1'b0), .i_last_was_data(1'b0), .i_addr_update(1'b0), .i_ack_rx_status, .i_seq_done,
      .i_timer_tick, .o_tx_byte, .o_tx_load, .o_seq_request, .o_ack_value, .o_bit_tick, .o_sample_at_end,
      .o_shift_on_rise, .o_spi_master, .o_spi_slave, .o_ss_control, .o_i2c_master, .o_i2c_slave,
      .o_addr_10bit, .o_start_stop_irq, .o_general_call, .o_mode_reserved, .o_spi_pins_on,
      .o_i2c_pins_on, .o_sck_idle_level, .o_scl_hold_low);
   sspc_engine_model u_peer (.i_clock, .i_rst_n, .i_kick(kick), .i_kick_byte(kick_byte), .i_talk(talk),
      .i_slow(slow), .i_tx_load(o_tx_load), .i_tx_byte(o_tx_byte), .i_seq_request(o_seq_request),
      .o_byte_done(i_byte_done), .o_rx_byte(i_rx_byte), .o_shift_busy(i_shift_busy), .o_tx_busy(i_tx_busy),
      .o_seq_done(i_seq_done));
   // Clock, timer tick and hang limit
   always #10 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      i_timer_tick <= ~i_timer_tick;
      cycles <= cycles + 1;
      ticks <= ticks + o_bit_tick;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge i_clock) rd_seen <= i_rd;
   always @(negedge i_clock) begin
      if (rd_seen) begin
         chk("read data", expq.pop_front(), o_rdata);
      end
   end
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      expq.push_back(e);
      @(posedge i_clock);
      i_rd <= 1'b0;
   endtask
   task automatic send(input logic [7:0] b);
      @(posedge i_clock);
      kick <= 1'b1;
      kick_byte <= b;
      @(posedge i_clock);
      kick <= 1'b0;
   endtask
   task automatic cond(input logic [1:0] s);
      @(posedge i_clock);
      {i_stop_seen, i_start_seen} <= s;
      @(posedge i_clock);
      {i_stop_seen, i_start_seen} <= 2'b00;
   endtask
   // Bounded wait for a finished byte or bus condition
   task automatic wait_evt;
      int n;
      n = 0;
      while (i_byte_done !== 1'b1 && i_seq_done === 5'h00 && n < 40) begin
         @(negedge i_clock);
         n++;
      end
      if (n == 40) n_mismatch++;
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      logic [7:0] b1, b2;
      int n0;
      void'($urandom(32'h231597d1));
      b1 = $urandom;
      // Second byte always differs, so a dropped byte is visible
      b2 = b1 ^ (8'($urandom) | 8'h01);
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         rd(a[1:0], 8'h00);
      end
      // Every mode code, enabled, then the port switched off
      for (int m = 0; m < 16; m++) begin
         wr(2'h1, 8'h20 | m[7:0]);
         @(negedge i_clock);
         chk("spi pins", {7'h0, m < 6}, {7'h0, o_spi_pins_on});
         chk("reserved", {7'h0, m inside {9, 10, 12, 13}}, {7'h0, o_mode_reserved});
         chk("pins", {6'h0, m == 4, m inside {6, 7, 8, 11, 14, 15}}, {6'h0, o_ss_control, o_i2c_pins_on});
         chk("i2c slave", {6'h0, m inside {7, 15}, m > 13}, {6'h0, o_addr_10bit, o_start_stop_irq});
         rd(2'h1, 8'h20 | m[7:0]);
      end
      wr(2'h1, 8'h05);
      @(negedge i_clock);
      chk("spi pins", 8'h00, {7'h0, o_spi_pins_on});
      // All polarity, edge and phase combinations in master mode
      for (int i = 0; i < 8; i++) begin
         wr(2'h1, {3'b001, i[0], 4'h0});
         wr(2'h0, {i[2:1], 6'h00});
         @(negedge i_clock);
         chk("idle level", {7'h0, i[0]}, {7'h0, o_sck_idle_level});
         chk("shift edge", {7'h0, i[1] ^ i[0]}, {7'h0, o_shift_on_rise});
         chk("sample phase", {7'h0, i[2]}, {7'h0, o_sample_at_end});
         rd(2'h0, {i[2:1], 6'h00});
      end
      // Slave: second unread byte overflows and is dropped
      wr(2'h1, 8'h25);
      wr(2'h0, 8'h00);
      send(b1);
      wait_evt;
      rd(2'h0, 8'h01);
      send(b2);
      wait_evt;
      rd(2'h1, 8'h65);
      rd(2'h3, b1);
      rd(2'h0, 8'h00);
      wr(2'h1, 8'h25);
      send(b2);
      wr(2'h3, b1);
      wait_evt;
      rd(2'h1, 8'ha5);
      rd(2'h3, b2);
      // Master: back-to-back bytes never overflow
      wr(2'h1, 8'h20);
      wr(2'h3, b1);
      wait_evt;
      wr(2'h3, b2);
      wait_evt;
      rd(2'h1, 8'h20);
      rd(2'h3, ~b2);
      // Any sixteen clocks of a running divide-by-4 hold four bit ticks
      n0 = ticks;
      repeat (16) @(posedge i_clock);
      chk("bit rate", 8'h04, 8'(ticks - n0));
      // Bus master: each condition, prompt and slow in turn, with a refused second request
      wr(2'h1, 8'h28);
      i_ack_rx_status <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         slow <= k[0];
         wr(2'h2, 8'h20 | (8'h01 << k));
         wr(2'h2, 8'h3f);
         rd(2'h2, 8'h60 | (8'h01 << k));
         @(negedge i_clock);
         chk("ack value", 8'h01, {7'h0, o_ack_value});
         wait_evt;
         rd(2'h2, 8'h60);
      end
      talk <= 1'b1;
      wr(2'h3, b1);
      @(posedge i_clock);
      rd(2'h0, 8'h04);
      wait_evt;
      rd(2'h3, ~b1);
      i_bus_blocked <= 1'b1;
      wr(2'h3, b2);
      i_bus_blocked <= 1'b0;
      rd(2'h1, 8'ha8);
      wr(2'h1, 8'h28);
      cond(2'b01);
      rd(2'h0, 8'h08);
      cond(2'b10);
      rd(2'h0, 8'h10);
      wr(2'h1, 8'h08);
      rd(2'h0, 8'h00);
      // Bus slave: overflow on receive only, clock hold follows polarity
      talk <= 1'b0;
      wr(2'h1, 8'h26);
      wr(2'h2, 8'h80);
      @(negedge i_clock);
      chk("clock hold", 8'h03, {6'h0, o_general_call, o_scl_hold_low});
      send(b1);
      wait_evt;
      send(b2);
      wait_evt;
      rd(2'h1, 8'h66);
      wr(2'h1, 8'h36);
      @(negedge i_clock);
      chk("clock hold", 8'h02, {6'h0, o_general_call, o_scl_hold_low});
      talk <= 1'b1;
      send(b2);
      wait_evt;
      rd(2'h1, 8'h36);
      rd(2'h3, b2);
      repeat (2) @(posedge i_clock);
      conclude();
   end
endmodule
bind sspc_regs sspc_regs_monitor u_mon (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_shift_busy,
   .i_bus_blocked, .i_seq_done, .o_tx_load, .o_seq_request, .o_sample_at_end, .o_shift_on_rise,
   .o_spi_master, .o_spi_slave, .o_i2c_master, .o_mode_reserved, .o_spi_pins_on, .o_sck_idle_level);
`default_nettype wire
